// file: core/sram_pkg.sv
// Contract
// - Address, write data and read/write control are sampled on rising clock edges only.
// - Sleep and output enable act asynchronously; output enable high kills drivers at once.
// - A write starts on a clock edge and completes internally; no external pulse.
// - Pipelined reads hold data in an output register, driven at the next edge.
// - Double late write when pipelined, single late write when flow-through; no dead cycles.
// - Mode-select low picks flow-through, high picks pipelined.
// - Burst-order input low gives linear order, high gives interleaved order.
// - On load the counter preloads from the two low address bits; the rest is upper.
// - Data is four 9-bit lanes, each written only when its own strobe is low.
// - Three chip selects (low, high, low); selected only when all three are asserted.
// - Write-enable low on a command edge requests a write, high requests a read.
// - Clock-enable is active low; edges with it high are ignored.
// - Sleep high enters power-down; sleep low resumes normal operation.
// - Advance/load chooses between loading a new address and advancing the burst.
// - Write data arrives on the third edge pipelined, the second edge flow-through.
// - The burst counter is 2 bits and advances on every continue cycle.
// - While clock-enable is deasserted all state stays unchanged except the sleep synchroniser and the driver enable.
package sram_pkg;
  localparam int LANE_W_DEF = 9;
  localparam int LANES = 4;
  localparam int UPPER_W_DEF = 6;
  localparam logic [1:0] CNT_RST = 2'h0;
  localparam logic [1:0] CNT_STEP = 2'h1;
  localparam logic [3:0] LANES_NONE = 4'h0;

  // Burst command in flight, Gray coded along idle, read, write
  typedef enum logic [1:0] {
    OP_DESEL = 2'b00,
    OP_READ = 2'b01,
    OP_WRITE = 2'b11
  } op_t;
endpackage

// file: core/burst_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module burst_sequencer (
  input wire logic [1:0] start,
  input wire logic [1:0] count,
  input wire logic linear_order_select_n,
  output logic [1:0] low_addr
);
  // Low address bits for a burst step, wrapping inside the group of four
  always_comb begin
    if (!linear_order_select_n) begin
      low_addr = start + count;
    end else begin
      low_addr = start ^ count;
    end
  end
endmodule
`default_nettype wire

// file: core/sync_burst_sram_interface.sv
`timescale 1ns/10ps
`default_nettype none
module sync_burst_sram_interface
  import sram_pkg::*;
#(
  parameter int UPPER_W = UPPER_W_DEF,
  parameter int LANE_W = LANE_W_DEF
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clock_enable_n,
  input wire logic sleep_request,
  input wire logic output_enable_n,
  input wire logic flow_through_select_n,
  input wire logic linear_order_select_n,
  input wire logic advance_load,
  input wire logic select_first_n,
  input wire logic select_second,
  input wire logic select_third_n,
  input wire logic write_enable_n,
  input wire logic lane_a_write_n,
  input wire logic lane_b_write_n,
  input wire logic lane_c_write_n,
  input wire logic lane_d_write_n,
  input wire logic [UPPER_W-1:0] address,
  input wire logic [1:0] burst_start_bits,
  input wire logic [LANE_W-1:0] lane_a_io_in,
  input wire logic [LANE_W-1:0] lane_b_io_in,
  input wire logic [LANE_W-1:0] lane_c_io_in,
  input wire logic [LANE_W-1:0] lane_d_io_in,
  output logic [LANE_W-1:0] lane_a_io_out,
  output logic [LANE_W-1:0] lane_b_io_out,
  output logic [LANE_W-1:0] lane_c_io_out,
  output logic [LANE_W-1:0] lane_d_io_out,
  output logic lane_a_io_oe,
  output logic lane_b_io_oe,
  output logic lane_c_io_oe,
  output logic lane_d_io_oe,
  output logic powered_down
);
  localparam int AW = UPPER_W + 2;
  localparam int DEPTH = 2 ** AW;
  localparam int DW = LANES * LANE_W;

  // Refuse sizes the flip-flop array cannot serve
  if (UPPER_W < 1 || UPPER_W > 16 || LANE_W < 1) begin : g_bad_size
    $error("sync_burst_sram_interface: unsupported UPPER_W or LANE_W");
  end

  logic slp_meta_q, slp_q;
  logic run, sel, load, ft_mode;
  op_t op_q, op_d;
  logic [UPPER_W-1:0] upper_q, upper_d;
  logic [1:0] start_q, start_d, cnt_q, cnt_d, low_addr;
  logic [AW-1:0] cur_addr, wr_addr;
  logic [3:0] lanes_req, lane_we;
  logic a_wr_q, a_wr_d, b_wr_q, b_wr_d;
  logic [AW-1:0] a_addr_q, a_addr_d, b_addr_q, b_addr_d;
  logic [3:0] a_lanes_q, a_lanes_d, b_lanes_q, b_lanes_d;
  logic [DW-1:0] din, rd_word, rd_q, rd_d, out_q, out_d;
  logic rd_v_q, rd_v_d, drv_q, drv_d, oe_q;
  logic cmd_rd, cmd_wr;

  // Sleep synchroniser for the internal hold
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      slp_meta_q <= 1'b0;
      slp_q <= 1'b0;
    end else begin
      slp_meta_q <= sleep_request;
      slp_q <= slp_meta_q;
    end
  end

  // Edge qualification and decode
  always_comb begin
    run = !clock_enable_n && !slp_q;
    sel = !select_first_n && select_second && !select_third_n;
    load = !advance_load;
    ft_mode = !flow_through_select_n;
    lanes_req = ~{lane_d_write_n, lane_c_write_n, lane_b_write_n, lane_a_write_n};
    din = {lane_d_io_in, lane_c_io_in, lane_b_io_in, lane_a_io_in};
  end

  // Burst address and command next state
  always_comb begin
    op_d = op_q;
    upper_d = upper_q;
    start_d = start_q;
    cnt_d = cnt_q;
    if (run) begin
      if (load) begin
        upper_d = address;
        start_d = burst_start_bits;
        cnt_d = CNT_RST;
        if (!sel) begin
          op_d = OP_DESEL;
        end else if (write_enable_n) begin
          op_d = OP_READ;
        end else begin
          op_d = OP_WRITE;
        end
      end else begin
        cnt_d = cnt_q + CNT_STEP;
      end
    end
  end

  burst_sequencer u_seq (
    .start(start_d),
    .count(cnt_d),
    .linear_order_select_n(linear_order_select_n),
    .low_addr(low_addr)
  );

  // Write pipeline stages and read capture
  always_comb begin
    cur_addr = {upper_d, low_addr};
    cmd_rd = run && (op_d == OP_READ);
    cmd_wr = run && (op_d == OP_WRITE);
    a_wr_d = a_wr_q;
    a_addr_d = a_addr_q;
    a_lanes_d = a_lanes_q;
    b_wr_d = b_wr_q;
    b_addr_d = b_addr_q;
    b_lanes_d = b_lanes_q;
    rd_d = rd_q;
    rd_v_d = rd_v_q;
    out_d = out_q;
    drv_d = drv_q;
    if (run) begin
      a_wr_d = cmd_wr;
      a_addr_d = cur_addr;
      a_lanes_d = cmd_wr ? lanes_req : LANES_NONE;
      b_wr_d = a_wr_q;
      b_addr_d = a_addr_q;
      b_lanes_d = a_lanes_q;
      rd_d = rd_word;
      rd_v_d = cmd_rd;
      if (ft_mode) begin
        out_d = rd_word;
        drv_d = cmd_rd;
      end else begin
        out_d = rd_q;
        drv_d = rd_v_q;
      end
    end
  end

  // Commit of late write data: second edge flow-through, third pipelined
  always_comb begin
    lane_we = LANES_NONE;
    wr_addr = ft_mode ? a_addr_q : b_addr_q;
    if (run && ft_mode && a_wr_q) begin
      lane_we = a_lanes_q;
    end else if (run && !ft_mode && b_wr_q) begin
      lane_we = b_lanes_q;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      op_q <= OP_DESEL;
      upper_q <= '0;
      start_q <= CNT_RST;
      cnt_q <= CNT_RST;
      a_wr_q <= 1'b0;
      a_addr_q <= '0;
      a_lanes_q <= LANES_NONE;
      b_wr_q <= 1'b0;
      b_addr_q <= '0;
      b_lanes_q <= LANES_NONE;
      rd_q <= '0;
      rd_v_q <= 1'b0;
      out_q <= '0;
      drv_q <= 1'b0;
    end else begin
      op_q <= op_d;
      upper_q <= upper_d;
      start_q <= start_d;
      cnt_q <= cnt_d;
      a_wr_q <= a_wr_d;
      a_addr_q <= a_addr_d;
      a_lanes_q <= a_lanes_d;
      b_wr_q <= b_wr_d;
      b_addr_q <= b_addr_d;
      b_lanes_q <= b_lanes_d;
      rd_q <= rd_d;
      rd_v_q <= rd_v_d;
      out_q <= out_d;
      drv_q <= drv_d;
    end
  end

  // Driver enable, cleared at once by output enable or sleep
  always_ff @(posedge mclk or posedge sys_rst or posedge output_enable_n or posedge sleep_request) begin
    if (sys_rst || output_enable_n || sleep_request) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= drv_d;
    end
  end

  // Per-lane storage, write strobe and read path
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [LANE_W-1:0] mem_q [DEPTH];
    always_ff @(posedge mclk) begin
      if (lane_we[g]) begin
        mem_q[wr_addr] <= din[g*LANE_W +: LANE_W];
      end
    end
    assign rd_word[g*LANE_W +: LANE_W] = mem_q[cur_addr];
  end

  // Pin outputs straight from flip-flops
  assign lane_a_io_out = out_q[0*LANE_W +: LANE_W];
  assign lane_b_io_out = out_q[1*LANE_W +: LANE_W];
  assign lane_c_io_out = out_q[2*LANE_W +: LANE_W];
  assign lane_d_io_out = out_q[3*LANE_W +: LANE_W];
  assign lane_a_io_oe = oe_q;
  assign lane_b_io_oe = oe_q;
  assign lane_c_io_oe = oe_q;
  assign lane_d_io_oe = oe_q;
  assign powered_down = slp_q;

  // Checks on the command, burst and data paths
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_wr_cmd;
    run && load && sel && !write_enable_n && (lanes_req != LANES_NONE);
  endsequence
  sequence s_abort_cmd;
    run && load && sel && !write_enable_n && (lanes_req == LANES_NONE);
  endsequence
  sequence s_rd_cmd;
    run && load && sel && write_enable_n;
  endsequence

  a_pl_write_lag: assert property (s_wr_cmd ##0 !ft_mode ##1 run ##1 run |-> lane_we != LANES_NONE)
    else $error("pipelined write not committed on third edge");
  a_ft_write_lag: assert property (s_wr_cmd ##0 ft_mode ##1 run |-> lane_we != LANES_NONE)
    else $error("flow-through write not committed on second edge");
  a_abort_quiet: assert property (s_abort_cmd ##0 ft_mode ##1 run |-> lane_we == LANES_NONE)
    else $error("write abort modified memory");
  a_pl_abort_quiet: assert property (s_abort_cmd ##0 !ft_mode ##1 run ##1 run |-> lane_we == LANES_NONE)
    else $error("pipelined write abort modified memory");
  a_stall_hold: assert property (!run |=> $stable(cnt_q) && $stable(op_q) && $stable(out_q) && $stable(a_wr_q))
    else $error("state changed while clock disabled");
  a_deselect_cmd: assert property (run && load && !sel |=> op_q == OP_DESEL && !a_wr_q)
    else $error("unselected device accepted a command");
  a_load_preload: assert property (run && load |=> cnt_q == CNT_RST
    && start_q == $past(burst_start_bits) && upper_q == $past(address))
    else $error("burst load did not preload counter and address");
  a_burst_step: assert property (run && !load |=> cnt_q == $past(cnt_q) + CNT_STEP && $stable(upper_q))
    else $error("burst counter did not advance");
  a_pl_read_out: assert property (s_rd_cmd ##0 !ft_mode ##1 run |=> drv_q && out_q == $past(rd_q))
    else $error("pipelined read data not driven on next edge");
  a_oe_override: assert property (output_enable_n || sleep_request |-> !oe_q)
    else $error("drivers on while output enable deasserted");
  a_write_no_drive: assert property (run && load && sel && !write_enable_n && ft_mode |=> !drv_q)
    else $error("drivers on during flow-through write");
endmodule
`default_nettype wire

// file: dv/sram_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
module sram_ctrl_model (
  input wire logic mclk,
  input wire logic flow_through_select_n,
  input wire logic [35:0] rd_word,
  input wire logic [3:0] lane_oe,
  output logic clock_enable_n,
  output logic advance_load,
  output logic select_first_n,
  output logic select_second,
  output logic select_third_n,
  output logic write_enable_n,
  output logic [3:0] strobe_n,
  output logic [5:0] address,
  output logic [1:0] burst_start_bits,
  output logic [35:0] wr_word
);
  logic [35:0] rd_q[4];
  logic [3:0] oe_q[4];
  // Idle bus: deselected load
  initial begin
    {clock_enable_n, advance_load, select_first_n, select_second, select_third_n} = 5'h05;
    {write_enable_n, strobe_n, address, burst_start_bits, wr_word} = '1;
  end
  // One stalled edge, all else held
  task automatic hold();
    clock_enable_n = 1'b1;
    @(posedge mclk);
    #1;
    clock_enable_n = 1'b0;
  endtask
  // Load, continue beats, then deselect while the data pipe drains
  task automatic xfer(input logic we_n, input logic [2:0] sel, input logic [5:0] adr, input logic [1:0] st,
    input int n, input logic [3:0] stb_n, input logic [3:0][35:0] wd, input bit stall);
    int lat;
    lat = flow_through_select_n ? 2 : 1;
    for (int i = 0; i < n + lat; i++) begin
      if (stall && i == 2)
        hold();
      if (i == 0)
        {advance_load, select_first_n, select_second, select_third_n} = {1'b0, sel};
      else if (i >= n)
        {advance_load, select_first_n} = 2'b01;
      else
        advance_load = 1'b1;
      {write_enable_n, strobe_n, address, burst_start_bits} = {we_n, stb_n, adr, st};
      wr_word = (!we_n && i >= lat && i - lat < n) ? wd[i - lat] : ~wr_word;
      @(posedge mclk);
      #1;
      if (i + 1 >= lat && i + 1 - lat < n) begin
        rd_q[i + 1 - lat] = rd_word;
        oe_q[i + 1 - lat] = lane_oe;
      end
    end
  endtask
  // Read load, then park on a stall with the data standing; or release the stall and deselect
  task automatic park(input logic [5:0] adr, input logic [1:0] st, input bit on);
    if (on) begin
      {advance_load, select_first_n, select_second, select_third_n} = 4'h2;
      {write_enable_n, address, burst_start_bits} = {1'b1, adr, st};
      @(posedge mclk);
      #1;
      clock_enable_n = 1'b1;
    end else begin
      clock_enable_n = 1'b0;
      {advance_load, select_first_n} = 2'b01;
      @(posedge mclk);
      #1;
    end
  endtask
endmodule
`default_nettype wire

// file: dv/test_sync_burst_sram_interface.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module test_sync_burst_sram_interface;
  import sram_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic sleep_request = 1'b0;
  logic output_enable_n = 1'b0;
  logic flow_through_select_n = 1'b1;
  logic linear_order_select_n = 1'b0;
  wire logic clock_enable_n, advance_load, select_first_n, select_second, select_third_n, write_enable_n;
  wire logic powered_down;
  wire logic [3:0] strobe_n, lane_oe;
  wire logic [5:0] address;
  wire logic [1:0] burst_start_bits;
  wire logic [35:0] wr_word, rd_word;
  logic [35:0] ref_mem[256];
  logic [3:0][35:0] wd;
  logic [2:0] dsel[3] = '{3'b110, 3'b000, 3'b011};
  int n_errors = 0;
  int checks_done = 0;
  always #2 mclk = ~mclk;
  sync_burst_sram_interface i_sync_burst_sram_interface (
    .mclk, .sys_rst, .clock_enable_n, .sleep_request, .output_enable_n, .flow_through_select_n,
    .linear_order_select_n, .advance_load, .select_first_n, .select_second, .select_third_n,
    .write_enable_n, .address, .burst_start_bits, .powered_down,
    .lane_a_write_n(strobe_n[0]), .lane_b_write_n(strobe_n[1]),
    .lane_c_write_n(strobe_n[2]), .lane_d_write_n(strobe_n[3]),
    .lane_a_io_in(wr_word[8:0]), .lane_b_io_in(wr_word[17:9]),
    .lane_c_io_in(wr_word[26:18]), .lane_d_io_in(wr_word[35:27]),
    .lane_a_io_out(rd_word[8:0]), .lane_b_io_out(rd_word[17:9]),
    .lane_c_io_out(rd_word[26:18]), .lane_d_io_out(rd_word[35:27]),
    .lane_a_io_oe(lane_oe[0]), .lane_b_io_oe(lane_oe[1]),
    .lane_c_io_oe(lane_oe[2]), .lane_d_io_oe(lane_oe[3])
  );
  sram_ctrl_model i_sram_ctrl_model (
    .mclk, .flow_through_select_n, .rd_word, .lane_oe, .clock_enable_n, .advance_load, .select_first_n,
    .select_second, .select_third_n, .write_enable_n, .strobe_n, .address, .burst_start_bits, .wr_word
  );
  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // New write pattern, lanes distinct
  task automatic fill(input logic [8:0] b);
    for (int i = 0; i < 4; i++)
      wd[i] = {b + 9'h60, b + 9'h41, b + 9'h22, b} ^ {4{9'(i * 5)}};
  endtask
  // Reset with new mode and burst order
  task automatic phase(input logic ft_n, input logic lbo_n);
    sys_rst = 1'b1;
    flow_through_select_n = ft_n;
    linear_order_select_n = lbo_n;
    repeat (2) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
  endtask
  // Transfer, then update reference or check read beats
  task automatic run(input logic we_n, input logic [2:0] sel, input logic [5:0] adr, input logic [1:0] st,
    input int n, input logic [3:0] stb_n, input bit stall);
    logic [7:0] wa;
    logic ok;
    ok = (sel == 3'b010);
    i_sram_ctrl_model.xfer(we_n, sel, adr, st, n, stb_n, wd, stall);
    for (int j = 0; j < n; j++) begin
      wa = {adr, linear_order_select_n ? st ^ j[1:0] : st + j[1:0]};
      if (!we_n && ok) begin
        for (int k = 0; k < 4; k++)
          if (!stb_n[k])
            ref_mem[wa][k * 9 +: 9] = wd[j][k * 9 +: 9];
      end else if (we_n) begin
        `CHK("read oe", (ok && !output_enable_n) ? 4'hf : 4'h0, i_sram_ctrl_model.oe_q[j])
        if (ok && !output_enable_n)
          `CHK("read data", ref_mem[wa], i_sram_ctrl_model.rd_q[j])
      end
    end
  endtask
  // Tests
  initial begin
    repeat (2) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    fill(9'h0a5);
    run(1'b0, 3'b010, 6'h05, 2'h1, 4, 4'h0, 1'b1);
    run(1'b1, 3'b010, 6'h05, 2'h2, 4, 4'hf, 1'b0);
    fill(9'h13c);
    run(1'b0, 3'b010, 6'h05, 2'h0, 1, 4'hd, 1'b0);
    run(1'b0, 3'b010, 6'h05, 2'h3, 1, 4'hf, 1'b0);
    run(1'b1, 3'b010, 6'h05, 2'h0, 4, 4'hf, 1'b1);
    foreach (dsel[k]) begin
      run(1'b0, dsel[k], 6'h05, 2'h1, 1, 4'h0, 1'b0);
      run(1'b1, dsel[k], 6'h05, 2'h1, 1, 4'hf, 1'b0);
    end
    run(1'b1, 3'b010, 6'h05, 2'h0, 4, 4'hf, 1'b0);
    $display("test pipelined linear done");
    phase(1'b0, 1'b1);
    fill(9'h07e);
    run(1'b0, 3'b010, 6'h09, 2'h2, 4, 4'h0, 1'b1);
    run(1'b0, 3'b010, 6'h09, 2'h1, 1, 4'hf, 1'b0);
    run(1'b1, 3'b010, 6'h09, 2'h1, 4, 4'hf, 1'b1);
    output_enable_n = 1'b1;
    run(1'b1, 3'b010, 6'h09, 2'h3, 2, 4'hf, 1'b0);
    output_enable_n = 1'b0;
    i_sram_ctrl_model.park(6'h09, 2'h3, 1'b1);
    `CHK("park oe", 4'hf, lane_oe)
    `CHK("park data", ref_mem[8'h27], rd_word)
    sleep_request = 1'b1;
    #1;
    `CHK("sleep oe now", 4'h0, lane_oe)
    repeat (3) @(posedge mclk);
    #1;
    `CHK("sleep flag", 1'b1, powered_down)
    `CHK("sleep oe", 4'h0, lane_oe)
    sleep_request = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    `CHK("wake flag", 1'b0, powered_down)
    `CHK("wake oe", 4'hf, lane_oe)
    i_sram_ctrl_model.park(6'h09, 2'h3, 1'b0);
    run(1'b1, 3'b010, 6'h09, 2'h0, 4, 4'hf, 1'b0);
    $display("test flow-through interleaved done");
    test_done();
  end
  // Watchdog
  initial begin
    #20000;
    n_errors++;
    test_done();
  end
endmodule
`default_nettype wire
